// >>> csd_alu.sv
// Purpose: integer divide-step and bit-test datapath of the cpu
// Assumes: operations come from same-clock instruction logic, no synchronisers needed
// Notes:   a divide run takes repeat_counter+1 clocks after the request is taken
//
// Function
// RQ1: bit test ANDs operands, sets flags only
// RQ2: non-negative difference kept, shifted, lsb one
// RQ3: negative difference dropped, dividend shifted, lsb zero
// RQ4: operands are positive 32-bit words
// RQ5: after i-j+1 steps quotient low, remainder high
// RQ6: caller aligns divisor before the first step
// RQ7: caller supplies positive operands, handles signs
// RQ8: repeat counter N gives N+1 executions
`timescale 1ns/10ps
`default_nettype none

module csd_alu
   import csd_pkg::*;
#(
   parameter int DATA_W = CSD_DATA_W,   // datapath width
   parameter int CNT_W  = CSD_CNT_W     // repeat counter width
) (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              op_valid,
   output logic                   op_ready,
   input  wire csd_op_t           op_code,
   input  wire logic [DATA_W-1:0] operand_a,
   input  wire logic [DATA_W-1:0] operand_b,
   input  wire logic [CNT_W-1:0]  repeat_counter,
   output logic                   busy,
   output logic                   done,
   output logic      [DATA_W-1:0] result,
   output logic                   flag_zero,
   output logic                   flag_neg
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   csd_state_t        state_q;       // sequencer state
   csd_state_t        state_d;       // next sequencer state
   logic [DATA_W-1:0] acc_q;         // running dividend / final result
   logic [DATA_W-1:0] acc_d;         // next dividend
   logic [DATA_W-1:0] div_q;         // aligned divisor held for the run
   logic [DATA_W-1:0] div_d;         // next divisor
   logic [CNT_W-1:0]  cnt_q;         // remaining steps minus one
   logic [CNT_W-1:0]  cnt_d;         // next count
   logic              done_q;        // one-cycle completion pulse
   logic              done_d;        // next completion pulse
   logic              zf_q;          // zero flag
   logic              zf_d;          // next zero flag
   logic              nf_q;          // negative flag
   logic              nf_d;          // next negative flag

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   wire logic              take_w;      // request accepted this cycle
   wire logic              tst_w;       // accepted bit test
   wire logic              sub_w;       // accepted divide run
   wire logic              run_w;       // a step executes this cycle
   wire logic              last_w;      // this step is the final one
   wire logic [DATA_W-1:0] and_w;       // bit-test product
   wire logic [DATA_W-1:0] step_w;      // dividend after one step
   wire logic              kept_w;      // step kept its difference

   assign op_ready = (state_q == CSD_ST_IDLE);            // refused while a run is active
   assign take_w   = op_valid & op_ready;
   assign tst_w    = take_w & (op_code == CSD_OP_BIT_TEST);
   assign sub_w    = take_w & (op_code == CSD_OP_COND_SUB);
   assign run_w    = (state_q == CSD_ST_RUN);
   assign last_w   = run_w & (cnt_q == CSD_ZERO_CNT[CNT_W-1:0]);  // [RQ8]
   assign and_w    = operand_a & operand_b;                // [RQ1]

   // one step of the conditional subtract on the held operands
   csd_step #(
      .DATA_W        (DATA_W)
   ) u_step (
      .dividend      (acc_q),                               // [RQ4]
      .divisor       (div_q),                               // [RQ6]
      .next_dividend (step_w),
      .diff_kept     (kept_w)
   );

   // ------------------------------------------------------------------
   // next-state selection
   // ------------------------------------------------------------------
   // sequencer: idle until a divide request, then count down to zero
   always_comb begin
      state_d = state_q;
      case (state_q)
         CSD_ST_IDLE: begin
            if (sub_w) begin
               state_d = CSD_ST_RUN;
            end
         end
         CSD_ST_RUN: begin
            if (last_w) begin
               state_d = CSD_ST_IDLE;                      // [RQ8]
            end
         end
         default: begin
            state_d = CSD_ST_IDLE;
         end
      endcase
   end

   // dividend: loaded on a divide request, stepped each run cycle
   // a bit test never writes it
   assign acc_d = sub_w ? operand_a                         // [RQ4]
                : run_w ? step_w                            // [RQ2] [RQ3] [RQ5]
                : acc_q;                                    // [RQ1]

   // divisor is captured already aligned by the caller
   assign div_d = sub_w ? operand_b : div_q;                // [RQ6]

   // counter holds N at the first step, so N+1 steps run
   assign cnt_d = sub_w  ? repeat_counter                   // [RQ8]
                : (run_w & ~last_w) ? cnt_q - CSD_ONE_CNT[CNT_W-1:0]
                : cnt_q;

   // completion pulse follows the final step
   assign done_d = last_w;

   // flags follow the bit-test product only
   assign zf_d = tst_w ? (and_w == CSD_ZERO_WORD[DATA_W-1:0]) : zf_q;  // [RQ1]
   assign nf_d = tst_w ? and_w[DATA_W-1] : nf_q;                      // [RQ1]

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // control state
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= CSD_ST_IDLE;
         cnt_q   <= CSD_ZERO_CNT[CNT_W-1:0];
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         done_q  <= done_d;
      end
   end

   // data path
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         acc_q <= CSD_ZERO_WORD[DATA_W-1:0];
         div_q <= CSD_ZERO_WORD[DATA_W-1:0];
      end else begin
         acc_q <= acc_d;
         div_q <= div_d;
      end
   end

   // condition flags
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         zf_q <= 1'b0;
         nf_q <= 1'b0;
      end else begin
         zf_q <= zf_d;
         nf_q <= nf_d;
      end
   end

   // outputs
   assign busy      = run_w;
   assign done      = done_q;
   assign result    = acc_q;
   assign flag_zero = zf_q;
   assign flag_neg  = nf_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   logic [CNT_W:0]  steps_q;     // steps executed in the current run
   logic [CNT_W-1:0] n_q;        // repeat count of the current run

   // helper: count executed steps per run
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         steps_q <= '0;
         n_q     <= '0;
      end else if (sub_w) begin
         steps_q <= '0;
         n_q     <= repeat_counter;
      end else if (run_w) begin
         steps_q <= steps_q + 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_tst_keeps_acc: assert property (tst_w |=> $stable(acc_q) && state_q == CSD_ST_IDLE) // [RQ1]
      else $error("bit test changed the result register");

   a_tst_zero_flag: assert property (tst_w |=> flag_zero == ($past(and_w) == '0)) // [RQ1]
      else $error("zero flag does not follow the bit-test product");

   a_tst_neg_flag: assert property (tst_w |=> flag_neg == $past(operand_a[DATA_W-1] & operand_b[DATA_W-1])) // [RQ1]
      else $error("negative flag does not follow the bit-test product");

   a_step_kept_one: assert property (run_w && (acc_q >= div_q) && !acc_q[DATA_W-1] && !div_q[DATA_W-1]
                                     |=> result[0] == 1'b1 && result[DATA_W-1:1] == $past(acc_q - div_q)) // [RQ2]
      else $error("kept difference not shifted with a one");

   a_step_drop_zero: assert property (run_w && (acc_q < div_q) |=> result == {$past(acc_q[DATA_W-2:0]), 1'b0}) // [RQ3]
      else $error("negative difference not discarded");

   a_run_step_count: assert property (done |-> steps_q == {1'b0, n_q} + 1'b1) // [RQ8]
      else $error("run did not execute N+1 steps");

   a_quot_low_bits: assert property (sub_w && repeat_counter == 0 && operand_a >= operand_b
                                     && !operand_a[DATA_W-1] |=> ##1 done && result[0]) // [RQ5]
      else $error("single step did not yield quotient one");

   a_sub_op_busy: assert property (sub_w |=> busy && !op_ready) // [RQ4]
      else $error("divide request not taken into a run");

   c_bit_test:   cover property (tst_w ##1 flag_zero);
   c_short_run:  cover property (sub_w && repeat_counter == 3 ##[1:8] done);
   c_kept_step:  cover property (run_w && kept_w);
   c_drop_step:  cover property (run_w && !kept_w);

endmodule : csd_alu

`default_nettype wire

// >>> csd_step.sv
// Purpose: shared constants of the divide-step datapath, and one conditional-subtract step
// Assumes: dividend and aligned divisor are both positive 32-bit integers
// Notes:   the step is purely combinational; the caller holds the state
`timescale 1ns/10ps
`default_nettype none

package csd_pkg;
   localparam int          CSD_DATA_W    = 32;           // operand and result width
   localparam int          CSD_CNT_W     = 32;           // repeat counter width
   localparam int          CSD_SIGN_BIT  = 31;           // sign position of a data word
   localparam logic [31:0] CSD_ZERO_WORD = 32'h0000_0000; // reset value of data registers
   localparam logic [31:0] CSD_ZERO_CNT  = 32'h0000_0000; // reset and end value of counter
   localparam logic [31:0] CSD_ONE_CNT   = 32'h0000_0001; // counter decrement
   localparam logic        CSD_Q_ONE     = 1'b1;         // quotient bit for a kept difference
   localparam logic        CSD_Q_ZERO    = 1'b0;         // quotient bit for a discarded one

   // operation selector driven by the instruction stream
   typedef enum logic [1:0] {
      CSD_OP_NONE,
      CSD_OP_BIT_TEST,
      CSD_OP_COND_SUB
   } csd_op_t;

   // sequencer states
   typedef enum logic {
      CSD_ST_IDLE,
      CSD_ST_RUN
   } csd_state_t;
endpackage : csd_pkg

// one conditional-subtract step: keep difference or original, shift in quotient bit
module csd_step
   import csd_pkg::*;
#(
   parameter int DATA_W = CSD_DATA_W
) (
   input  wire logic [DATA_W-1:0] dividend,
   input  wire logic [DATA_W-1:0] divisor,
   output logic      [DATA_W-1:0] next_dividend,
   output logic                   diff_kept
);
   wire logic [DATA_W-1:0] diff_w;   // trial difference
   wire logic              neg_w;    // trial difference is negative

   assign diff_w    = dividend - divisor;               // [RQ2]
   assign neg_w     = diff_w[DATA_W-1];
   assign diff_kept = ~neg_w;
   // kept: shifted difference with a one; discarded: shifted dividend with a zero
   assign next_dividend = neg_w ? {dividend[DATA_W-2:0], CSD_Q_ZERO}  // [RQ3]
                                : {diff_w[DATA_W-2:0], CSD_Q_ONE};    // [RQ2]
endmodule : csd_step

`default_nettype wire

// >>> tb_conditional_subtract_divide_step.sv
// Purpose: self-checking bench of the divide-step and bit-test datapath
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   expected divide results in test_divide come from a bench-side step model
`timescale 1ns/10ps
`default_nettype none
module tb_conditional_subtract_divide_step;
   import csd_pkg::*;
   logic        sys_clk;        // 100 MHz clock
   logic        resetn;         // active-low reset
   logic        op_valid;       // request present
   csd_op_t     op_code;        // requested operation
   logic [31:0] operand_a;      // first operand or dividend
   logic [31:0] operand_b;      // second operand or aligned divisor
   logic [31:0] repeat_counter; // steps minus one
   logic        op_ready;       // idle, request may be taken
   logic        busy;           // step in progress
   logic        done;           // divide finished pulse
   logic [31:0] result;         // running dividend
   logic        flag_zero;      // zero flag
   logic        flag_neg;       // negative flag
   logic [1:0]  flags_e;        // expected flags {neg, zero}
   logic [31:0] res_e;          // expected result
   int          miscompares;    // mismatch count
   int          checks_done;    // comparison count
   int          cycles;         // timeout counter

   csd_alu u_dut (.sys_clk(sys_clk), .resetn(resetn), .op_valid(op_valid),
      .op_ready(op_ready), .op_code(op_code), .operand_a(operand_a),
      .operand_b(operand_b), .repeat_counter(repeat_counter), .busy(busy),
      .done(done), .result(result), .flag_zero(flag_zero), .flag_neg(flag_neg));

   // free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         end_sim();
      end
   end

   // verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim

   // compare one value
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask : chk

   // bench model of one step: keep non-negative difference, else shift
   function automatic logic [31:0] ref_step(input logic [31:0] d, input logic [31:0] v);
      logic [31:0] diff;
      diff = d - v;
      if (diff[31] == 1'b0) return {diff[30:0], 1'b1};
      return {d[30:0], 1'b0};
   endfunction : ref_step

   // present one request and hold it until an edge that sees op_ready high
   task automatic issue(input csd_op_t op, input logic [31:0] a, input logic [31:0] b,
                        input logic [31:0] n);
      @(posedge sys_clk);
      op_valid       <= 1'b1;
      op_code        <= op;
      operand_a      <= a;
      operand_b      <= b;
      repeat_counter <= n;
      @(negedge sys_clk);
      while (op_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      op_valid <= 1'b0;
      #1;
   endtask : issue

   // bit test over a small table; result must not move
   task automatic test_bit_test();
      logic [31:0] ta [3] = '{32'hF0F0_F0F0, 32'h8000_0001, 32'h0000_0004};
      logic [31:0] tb [3] = '{32'h0F0F_0F0F, 32'h8000_0000, 32'h0000_0006};
      for (int k = 0; k < 3; k++) begin
         issue(CSD_OP_BIT_TEST, ta[k], tb[k], 32'h0000_0000);
         flags_e = {(ta[k] & tb[k]) >> 31 != 0, (ta[k] & tb[k]) == 0};
         chk("flag_zero", {31'h0, flags_e[0]}, {31'h0, flag_zero});
         chk("flag_neg", {31'h0, flags_e[1]}, {31'h0, flag_neg});
         chk("bt_result", res_e, result);
      end
      $display("test bit_test done");
   endtask : test_bit_test

   // divide run of n+1 steps with timing of busy and done
   task automatic test_divide(input logic [31:0] a, input logic [31:0] b, input logic [31:0] n);
      res_e = a;
      for (int k = 0; k <= int'(n); k++) res_e = ref_step(res_e, b);
      issue(CSD_OP_COND_SUB, a, b, n);
      chk("busy", 32'h1, {31'h0, busy});
      chk("busy_ready", 32'h0, {31'h0, op_ready});
      repeat (int'(n)) @(posedge sys_clk);
      #1;
      chk("early_done", 32'h0, {31'h0, done});
      @(posedge sys_clk);
      #1;
      chk("done", 32'h1, {31'h0, done});
      chk("div_result", res_e, result);
      chk("div_flags", {30'h0, flags_e}, {30'h0, flag_neg, flag_zero});
      @(posedge sys_clk);
      #1;
      chk("done_pulse", 32'h0, {31'h0, done});
      $display("test divide done");
   endtask : test_divide

   // bit test held while a run is busy: refused until ready, taken in the done cycle
   task automatic test_refused();
      res_e = 32'h0000_0036;
      issue(CSD_OP_COND_SUB, 32'h0000_0021, 32'h0000_0028, 32'h0000_0003);
      @(posedge sys_clk);
      op_valid  <= 1'b1;
      op_code   <= CSD_OP_BIT_TEST;
      operand_a <= 32'h8000_0000;
      operand_b <= 32'h8000_0000;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("refused_flag", 32'h0, {31'h0, flag_neg});
      chk("ready_at_done", 32'h1, {31'h0, op_ready});
      chk("done_with_req", 32'h1, {31'h0, done});
      chk("busy_result", res_e, result);
      @(posedge sys_clk);
      op_valid <= 1'b0;
      #1;
      chk("late_bt_flag", 32'h1, {31'h0, flag_neg});
      chk("late_bt_result", res_e, result);
      $display("test refused done");
   endtask : test_refused

   // no-operation request is taken and ignored
   task automatic test_no_op();
      issue(CSD_OP_NONE, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000);
      chk("none_busy", 32'h0, {31'h0, busy});
      chk("none_result", res_e, result);
      $display("test no_op done");
   endtask : test_no_op

   // main sequence
   initial begin
      resetn = 1'b0; op_valid = 1'b0; op_code = CSD_OP_NONE; operand_a = 32'h0000_0000;
      operand_b = 32'h0000_0000; repeat_counter = 32'h0000_0000;
      miscompares = 0; checks_done = 0; cycles = 0; res_e = 32'h0000_0000;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("rst_ready", 32'h1, {31'h0, op_ready});
      chk("rst_result", 32'h0, result);
      $display("test reset done");
      test_bit_test();
      test_divide(32'h0000_0021, 32'h0000_0028, 32'h0000_0003);
      chk("q_rem_33_5", 32'h0000_0036, result);
      test_divide(32'h0000_0064, 32'h0000_0070, 32'h0000_0004);
      chk("q_rem_100_7", 32'h0000_004E, result);
      test_divide(32'h0000_0009, 32'h0000_0009, 32'h0000_0000);
      test_refused();
      test_no_op();
      end_sim();
   end
endmodule : tb_conditional_subtract_divide_step
`default_nettype wire
